// File: nbcp_pkg.sv
package nbcp_pkg;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_A   = 8'h00;
    localparam logic [7:0] CMD_READ_B   = 8'h01;
    localparam logic [7:0] CMD_READ_C   = 8'h50;
    localparam logic [7:0] CMD_SIG      = 8'h90;
    localparam logic [7:0] CMD_STATUS   = 8'h70;
    localparam logic [7:0] CMD_PROG     = 8'h80;
    localparam logic [7:0] CMD_CONFIRM  = 8'h10;
    localparam logic [7:0] CMD_COPYBACK = 8'h8A;
    localparam logic [7:0] CMD_ERASE    = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
    localparam logic [7:0] CMD_RESET    = 8'hFF;
    // ------------------------------------------------------------
    // address layout and bus timing
    // ------------------------------------------------------------
    localparam int         ADDR_CYCLES  = 4;
    localparam int         A8_POS       = 8;
    localparam int         A25_POS      = 25;
    localparam int         PHASE_NS     = 40;
    localparam int         CLK_NS       = 8;
    localparam logic [3:0] PHASE_CYC    = 4'((PHASE_NS + CLK_NS - 1) / CLK_NS);
    // ------------------------------------------------------------
    // host request kinds
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        NBCP_OP_CMD   = 3'b000,
        NBCP_OP_ADDR  = 3'b001,
        NBCP_OP_WDATA = 3'b010,
        NBCP_OP_RDATA = 3'b011,
        NBCP_OP_IDLE  = 3'b100
    } nbcp_op_e;
endpackage

// File: nbcp_strobe.sv
`timescale 1ns/100ps
`default_nettype none
module nbcp_strobe
    import nbcp_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    output logic      phase_end,
    output logic      busy
);
    logic [3:0] cnt;
    // one bus cycle is two phases: strobe low, then strobe high
    logic       second;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt       <= 4'h0;
            second    <= 1'b0;
            busy      <= 1'b0;
            phase_end <= 1'b0;
        end else begin
            phase_end <= 1'b0;
            if (start && !busy) begin
                busy   <= 1'b1;
                cnt    <= PHASE_CYC;
                second <= 1'b0;
            end else if (busy) begin
                if (cnt == 4'h1) begin
                    phase_end <= 1'b1;
                    if (second) begin
                        busy <= 1'b0;
                    end else begin
                        second <= 1'b1;
                        cnt    <= PHASE_CYC;
                    end
                end else begin
                    cnt <= cnt - 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: nbcp_host.sv
`timescale 1ns/100ps
`default_nettype none
module nbcp_host
    import nbcp_pkg::*;
#(
    parameter int WIDE = 0
)(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        req_valid,
    input  wire logic [2:0]  req_op,
    input  wire logic [15:0] req_data,
    input  wire logic        prot_en,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    output logic [1:0]       area_ptr,
    output logic             ready_sync,
    output logic             chip_sel_n,
    output logic             cmd_latch_strobe,
    output logic             addr_latch_strobe,
    output logic             wr_strobe_n,
    output logic             rd_strobe_n,
    output logic             wr_prot_n,
    output logic [15:0]      dq_out,
    output logic [15:0]      dq_oe,
    input  wire logic [15:0] dq_in,
    input  wire logic        op_done_flag
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
    logic        rb_s1;

    always_ff @(posedge core_clk) begin
        dq_s1      <= dq_in;
        dq_s2      <= dq_s1;
        rb_s1      <= op_done_flag;
        ready_sync <= rb_s1;
    end

    // ------------------------------------------------------------
    // bus cycle sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        NBCP_IDLE = 2'b00,
        NBCP_LOW  = 2'b01,
        NBCP_HIGH = 2'b10
    } nbcp_state_e;

    nbcp_state_e state;
    nbcp_op_e    op;
    logic [7:0]  cur_cmd;
    logic        phase_end;
    logic        tim_busy;
    logic [2:0]  addr_cnt;
    logic        in_prog;
    logic        start;

    assign start = (state == NBCP_IDLE) && req_valid && req_ready;

    nbcp_strobe u_tim (
        .clk       (core_clk),
        .rst       (rst),
        .start     (start),
        .phase_end (phase_end),
        .busy      (tim_busy)
    );

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state             <= NBCP_IDLE;
            op                <= NBCP_OP_IDLE;
            req_ready         <= 1'b1;
            chip_sel_n        <= 1'b1;
            cmd_latch_strobe  <= 1'b0;
            addr_latch_strobe <= 1'b0;
            wr_strobe_n       <= 1'b1;
            rd_strobe_n       <= 1'b1;
            dq_out            <= 16'h0000;
            dq_oe             <= 16'h0000;
            cur_cmd           <= 8'h00;
        end else begin
            case (state)
                NBCP_IDLE: begin
                    if (start) begin
                        op        <= nbcp_op_e'(req_op);
                        req_ready <= 1'b0;
                        state     <= NBCP_LOW;
                        if (nbcp_op_e'(req_op) == NBCP_OP_IDLE) begin
                            chip_sel_n <= 1'b1;
                        end else begin
                            chip_sel_n <= 1'b0;
                        end
                        // read strobe stays high for every write-type cycle
                        cmd_latch_strobe  <= (nbcp_op_e'(req_op) == NBCP_OP_CMD);
                        addr_latch_strobe <= (nbcp_op_e'(req_op) == NBCP_OP_ADDR);
                        case (nbcp_op_e'(req_op))
                            NBCP_OP_CMD: begin
                                wr_strobe_n <= 1'b0;
                                dq_out      <= {8'h00, req_data[7:0]};
                                dq_oe       <= 16'h00FF;
                                cur_cmd     <= req_data[7:0];
                            end
                            NBCP_OP_ADDR: begin
                                wr_strobe_n <= 1'b0;
                                dq_out      <= {8'h00, req_data[7:0]};
                                dq_oe       <= 16'h00FF;
                            end
                            NBCP_OP_WDATA: begin
                                wr_strobe_n <= 1'b0;
                                dq_out      <= req_data;
                                dq_oe       <= (WIDE != 0) ? 16'hFFFF : 16'h00FF;
                            end
                            NBCP_OP_RDATA: begin
                                rd_strobe_n <= 1'b0;
                                dq_oe       <= 16'h0000;
                            end
                            default: begin
                                dq_oe <= 16'h0000;
                            end
                        endcase
                    end
                end
                NBCP_LOW: begin
                    if (phase_end) begin
                        wr_strobe_n <= 1'b1;
                        rd_strobe_n <= 1'b1;
                        state       <= NBCP_HIGH;
                    end
                end
                NBCP_HIGH: begin
                    if (phase_end) begin
                        cmd_latch_strobe  <= 1'b0;
                        addr_latch_strobe <= 1'b0;
                        dq_oe             <= 16'h0000;
                        req_ready         <= 1'b1;
                        state             <= NBCP_IDLE;
                    end
                end
                default: begin
                    state <= NBCP_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read data return
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_data  <= 16'h0000;
        end else begin
            rsp_valid <= 1'b0;
            // sampled at the end of the low phase; the phase covers access time plus sync delay
            if (state == NBCP_LOW && phase_end && op == NBCP_OP_RDATA) begin
                rsp_valid <= 1'b1;
                rsp_data  <= (WIDE != 0) ? dq_s2 : {8'h00, dq_s2[7:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // write protect and area pointer tracking
    // ------------------------------------------------------------
    logic cmd_done;
    assign cmd_done = (state == NBCP_HIGH) && phase_end && (op == NBCP_OP_CMD);

    // protect must already be high at the setup code's strobe edge, so it rises when that cycle starts
    logic prog_code;
    assign prog_code = (req_data[7:0] == CMD_PROG) || (req_data[7:0] == CMD_ERASE)
                       || (req_data[7:0] == CMD_COPYBACK);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_prot_n <= 1'b0;
            in_prog   <= 1'b0;
        end else if (start && req_op == 3'(NBCP_OP_CMD) && prog_code) begin
            in_prog   <= 1'b1;
            wr_prot_n <= !prot_en;
        end else if (cmd_done) begin
            if (cur_cmd == CMD_RESET) begin
                in_prog   <= 1'b0;
                wr_prot_n <= 1'b0;
            end else if (in_prog && cur_cmd != CMD_CONFIRM && cur_cmd != CMD_ERASE_GO
                         && cur_cmd != CMD_STATUS) begin
                // other codes while a sequence is open leave in_prog set, so the sequence stays open
                in_prog <= in_prog;
            end else if (cur_cmd == CMD_CONFIRM || cur_cmd == CMD_ERASE_GO) begin
                in_prog <= 1'b0;
            end
        end else if (in_prog && !ready_sync) begin
            wr_prot_n <= wr_prot_n;
        end else if (!in_prog && ready_sync) begin
            wr_prot_n <= 1'b0;
        end
    end

    // 0 = first half, 1 = second half, 2 = spare
    logic b_used;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            area_ptr <= 2'd0;
            b_used   <= 1'b0;
        end else if (cmd_done) begin
            case (cur_cmd)
                CMD_READ_A: area_ptr <= 2'd0;
                CMD_READ_B: area_ptr <= (WIDE != 0) ? area_ptr : 2'd1;
                CMD_READ_C: area_ptr <= 2'd2;
                CMD_RESET:  area_ptr <= 2'd0;
                default:    area_ptr <= area_ptr;
            endcase
            b_used <= 1'b0;
        end else if (area_ptr == 2'd1 && state == NBCP_HIGH && phase_end && op != NBCP_OP_ADDR) begin
            // second half covers one operation: revert once data moves
            area_ptr <= 2'd0;
        end
    end

    // ------------------------------------------------------------
    // address cycle count
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            addr_cnt <= 3'd0;
        end else if (cmd_done) begin
            addr_cnt <= 3'd0;
        end else if (state == NBCP_HIGH && phase_end && op == NBCP_OP_ADDR
                     && addr_cnt != 3'(ADDR_CYCLES)) begin
            addr_cnt <= addr_cnt + 3'd1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_cmd_latch;
        @(posedge core_clk) disable iff (rst)
        $rose(wr_strobe_n) && cmd_latch_strobe |-> !addr_latch_strobe && rd_strobe_n && !chip_sel_n;
    endproperty
    a_cmd_latch: assert property (p_cmd_latch) else $error("command cycle pins wrong");

    property p_addr_low;
        @(posedge core_clk) disable iff (rst)
        addr_latch_strobe && !wr_strobe_n |-> dq_oe == 16'h00FF;
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("address on upper lines");

    property p_strobe_len;
        @(posedge core_clk) disable iff (rst)
        $fell(wr_strobe_n) |-> !wr_strobe_n [*4];
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("write strobe too short");

    property p_reset_ptr;
        @(posedge core_clk) rst |=> area_ptr == 2'd0;
    endproperty
    a_reset_ptr: assert property (p_reset_ptr) else $error("pointer not first half");

    property p_rd_ret;
        @(posedge core_clk) disable iff (rst)
        $fell(rd_strobe_n) |-> ##[1:6] rsp_valid;
    endproperty
    a_rd_ret: assert property (p_rd_ret) else $error("read data not returned");

    property p_prot_setup;
        @(posedge core_clk) disable iff (rst)
        $rose(wr_strobe_n) && cmd_latch_strobe
        && (dq_out[7:0] == CMD_PROG || dq_out[7:0] == CMD_ERASE || dq_out[7:0] == CMD_COPYBACK)
        |-> wr_prot_n == !prot_en;
    endproperty
    a_prot_setup: assert property (p_prot_setup) else $error("protect wrong at setup code");
endmodule
`default_nettype wire

// File: nbcp_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module nbcp_flash_model
    import nbcp_pkg::*;
#(
    parameter int BUSY_NS = 400
)(
    input  wire logic        chip_sel_n,
    input  wire logic        cmd_latch_strobe,
    input  wire logic        addr_latch_strobe,
    input  wire logic        wr_strobe_n,
    input  wire logic        rd_strobe_n,
    input  wire logic        wr_prot_n,
    input  wire logic [15:0] dq,
    output logic [15:0]      q,
    output logic             q_en,
    output logic             busy
);
    // ------------------------------------------------------------
    // narrow memory, behavioural; no array, counters stand for it
    // ------------------------------------------------------------
    logic [7:0]  last_cmd  = 8'hFF;
    logic [7:0]  prev_cmd  = 8'hFF;
    logic [25:0] addr      = '0;
    logic [2:0]  addr_cnt  = '0;
    logic [1:0]  ptr       = '0;
    logic [9:0]  col       = '0;
    logic [15:0] last_word = '0;
    logic        setup_ok  = 1'b0;
    logic        go;
    int          prog_cnt  = 0;
    int          erase_cnt = 0;
    int          copy_cnt  = 0;
    initial begin
        q = '0;
        q_en = 1'b0;
        busy = 1'b0;
    end
    always @(posedge wr_strobe_n) begin
        go = 1'b0;
        if (!chip_sel_n && rd_strobe_n) begin
            if (cmd_latch_strobe && !addr_latch_strobe &&
                (!busy || dq[7:0] == CMD_STATUS || dq[7:0] == CMD_RESET)) begin
                prev_cmd = last_cmd;
                last_cmd = dq[7:0];
                addr_cnt = '0;
                case (last_cmd)
                    CMD_READ_A: ptr = 2'd0;
                    CMD_READ_B: ptr = 2'd1;
                    CMD_READ_C: ptr = 2'd2;
                    CMD_RESET: begin
                        ptr = 2'd0;
                        busy = 1'b0;
                    end
                    CMD_PROG, CMD_ERASE: setup_ok = wr_prot_n;
                    CMD_CONFIRM: go = prev_cmd == CMD_PROG && setup_ok && wr_prot_n;
                    CMD_ERASE_GO: go = prev_cmd == CMD_ERASE && setup_ok && wr_prot_n;
                    CMD_COPYBACK: go = prev_cmd == CMD_READ_A && wr_prot_n;
                    default: ;
                endcase
                if (go) begin
                    prog_cnt += int'(last_cmd == CMD_CONFIRM);
                    erase_cnt += int'(last_cmd == CMD_ERASE_GO);
                    copy_cnt += int'(last_cmd == CMD_COPYBACK);
                    busy = 1'b1;
                    busy <= #(BUSY_NS) 1'b0;
                end
            end else if (addr_latch_strobe && !cmd_latch_strobe && addr_cnt < 3'd4) begin
                case (addr_cnt)
                    3'd0: begin
                        // narrow model: a8 follows the pointer; a wide part never looks at it
                        addr[8:0] = {ptr == 2'd1, dq[7:0]};
                        col = (ptr == 2'd2) ? 10'(512 + dq[3:0]) : {1'b0, ptr[0], dq[7:0]};
                    end
                    3'd1: addr[16:9] = dq[7:0];
                    3'd2: addr[24:17] = dq[7:0];
                    default: addr[25] = dq[0];
                endcase
                if (addr_cnt == 3'd3 && ptr == 2'd1) begin
                    ptr = 2'd0;
                end
                addr_cnt++;
            end else if (!addr_latch_strobe && !cmd_latch_strobe) begin
                last_word = {8'h00, dq[7:0]};
            end
        end
    end
    // status shows the done bit only; array reads give a column pattern
    always @(negedge rd_strobe_n) begin
        if (!chip_sel_n && wr_strobe_n && !cmd_latch_strobe && !addr_latch_strobe) begin
            q = (last_cmd == CMD_STATUS) ? {9'h000, !busy, 6'h00} : {8'h00, col[7:0] + {col[9:8], 6'h00}};
            q_en = 1'b1;
            col++;
        end
    end
    // outputs float again once the read strobe returns high
    always @(posedge rd_strobe_n) begin
        q_en = 1'b0;
    end
    always @(posedge chip_sel_n) begin
        q_en = 1'b0;
    end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
    import nbcp_pkg::*;
;
    logic        core_clk  = 1'b0;
    logic        rst       = 1'b1;
    logic        req_valid = 1'b0;
    logic [2:0]  req_op    = 3'd4;
    logic [15:0] req_data  = '0;
    logic        prot_en   = 1'b0;
    logic        req_ready, rsp_valid, ready_sync, chip_sel_n, cmd_latch_strobe, addr_latch_strobe;
    logic        wr_strobe_n, rd_strobe_n, wr_prot_n, op_done_flag, q_en, busy;
    logic [1:0]  area_ptr;
    logic [15:0] rsp_data, dq_out, dq_oe, dq_in, q, rd_word;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;
    // released data lines show the inverse of the last value, not a stale copy
    assign dq_in = (dq_oe & dq_out) | (~dq_oe & (q_en ? q : ~q));
    assign op_done_flag = ~busy;
    nbcp_host #(.WIDE(0)) uut (.core_clk, .rst, .req_valid, .req_op, .req_data, .prot_en, .req_ready,
        .rsp_valid, .rsp_data, .area_ptr, .ready_sync, .chip_sel_n, .cmd_latch_strobe, .addr_latch_strobe,
        .wr_strobe_n, .rd_strobe_n, .wr_prot_n, .dq_out, .dq_oe, .dq_in, .op_done_flag);
    // busy long enough to outlast the four target address cycles of a copy-back
    nbcp_flash_model #(.BUSY_NS(800)) mdl (.chip_sel_n, .cmd_latch_strobe, .addr_latch_strobe, .wr_strobe_n,
        .rd_strobe_n, .wr_prot_n, .dq(dq_out), .q, .q_en, .busy);
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            test_done();
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
            mismatches++;
        end
    endtask
    task automatic req(input logic [2:0] op, input logic [15:0] data);
        int n;
        n = 0;
        rd_word = 'x;
        req_valid = 1'b1;
        req_op = op;
        req_data = data;
        @(negedge core_clk);
        req_valid = 1'b0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
            if (rsp_valid === 1'b1) begin
                rd_word = rsp_data;
            end
        end
        check("request finished", 1, req_ready);
    endtask
    task automatic cmd(input logic [7:0] c);
        req(NBCP_OP_CMD, {8'h00, c});
    endtask
    task automatic adr(input logic [25:0] a, input int first, input int last);
        logic [7:0] b [5];
        b = '{a[7:0], a[16:9], a[24:17], {7'h00, a[25]}, 8'hFF};
        for (int i = first; i <= last; i++) begin
            req(NBCP_OP_ADDR, {8'h00, b[i]});
        end
    endtask
    // busy must show on the synchronised flag before it clears
    task automatic wait_done;
        int n;
        n = 0;
        while (ready_sync !== 1'b0 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        check("busy seen", 0, ready_sync);
        n = 0;
        while (ready_sync !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        check("ready again", 1, ready_sync);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_cmds;
        logic [7:0] codes [3];
        codes = '{CMD_SIG, CMD_RESET, CMD_STATUS};
        foreach (codes[i]) begin
            cmd(codes[i]);
            check("command latched", codes[i], mdl.last_cmd);
        end
        req(NBCP_OP_RDATA, 16'h0000);
        check("status ready", 8'h40, rd_word[7:0]);
        req(NBCP_OP_IDLE, 16'h0000);
        check("deselected", 1, chip_sel_n);
        check("lines released", 0, dq_oe);
    endtask
    task automatic t_read;
        cmd(CMD_READ_A);
        adr(26'h2ABCE12, 0, 4);
        check("address cycles", 26'h2ABCE12, mdl.addr);
        req(NBCP_OP_RDATA, 16'h0000);
        check("first byte", 16'h0012, rd_word);
        req(NBCP_OP_RDATA, 16'h0000);
        check("next byte", 8'h13, rd_word[7:0]);
    endtask
    task automatic t_pointer;
        cmd(CMD_READ_B);
        check("second half", 1, area_ptr);
        adr(26'h0000034, 0, 3);
        check("a8 from pointer", 26'h0000134, mdl.addr);
        req(NBCP_OP_RDATA, 16'h0000);
        check("second half data", 8'h74, rd_word[7:0]);
        check("pointer reverts", 0, area_ptr);
        cmd(CMD_READ_C);
        adr(26'h0000005, 0, 3);
        req(NBCP_OP_RDATA, 16'h0000);
        check("spare data", 8'h85, rd_word[7:0]);
        cmd(CMD_SIG);
        check("spare persists", 2, area_ptr);
    endtask
    task automatic t_program;
        int n0;
        n0 = mdl.prog_cnt;
        cmd(CMD_READ_C);
        cmd(CMD_PROG);
        check("protect lifted", 1, wr_prot_n);
        check("area before program", 2, area_ptr);
        adr(26'h0004200, 0, 3);
        req(NBCP_OP_WDATA, 16'hBEA7);
        cmd(CMD_CONFIRM);
        cmd(CMD_SIG);
        check("busy ignores command", CMD_CONFIRM, mdl.last_cmd);
        wait_done();
        check("program done", n0 + 1, mdl.prog_cnt);
        check("program byte", 16'h00A7, mdl.last_word);
        prot_en = 1'b1;
        cmd(CMD_PROG);
        check("protect held", 0, wr_prot_n);
        adr(26'h0004200, 0, 3);
        req(NBCP_OP_WDATA, 16'h0055);
        cmd(CMD_CONFIRM);
        check("protected program", n0 + 1, mdl.prog_cnt);
        prot_en = 1'b0;
        cmd(CMD_RESET);
        check("area after reset command", 0, area_ptr);
    endtask
    task automatic t_erase_copy;
        int e0;
        int c0;
        int p0;
        e0 = mdl.erase_cnt;
        c0 = mdl.copy_cnt;
        p0 = mdl.prog_cnt;
        cmd(CMD_ERASE);
        adr(26'h3FFC000, 1, 3);
        cmd(CMD_ERASE_GO);
        wait_done();
        check("erase done", e0 + 1, mdl.erase_cnt);
        for (int k = 0; k < 2; k++) begin
            cmd(CMD_READ_A);
            adr(26'h0010000, 0, 3);
            cmd(CMD_COPYBACK);
            adr(26'h0020000, 0, 3);
            wait_done();
            if (k == 1) begin
                cmd(CMD_CONFIRM);
            end
        end
        check("copy back count", c0 + 2, mdl.copy_cnt);
        check("no extra program", p0, mdl.prog_cnt);
    endtask
    initial begin
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        check("area after reset", 0, area_ptr);
        check("idle select", 1, chip_sel_n);
        check("idle protect", 0, wr_prot_n);
        t_cmds();
        t_read();
        t_pointer();
        t_program();
        t_erase_copy();
        test_done();
    end
endmodule
`default_nettype wire
